// file: test/plc_line_model.sv
module plc_line_model (
  // polarity command from the bench
  input  wire logic [1:0] ring_sel,
  // ring presence pins
  output logic            ring_pos_pin,
  output logic            ring_neg_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // line delay keeps pin edges off the clock grid
  assign #7 {ring_neg_pin, ring_pos_pin} = ring_sel;
endmodule : plc_line_model

// file: test/plc_regs_props.sv
module plc_regs_props #(
  parameter int unsigned RING_HOLD_CYC    = 20,
  parameter int unsigned OFFHOOK_HOLD_CYC = 8
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  // framing
  input wire logic       sec_frame_req,
  input wire logic       sec_frame_grant,
  input wire logic       serial_width_16,
  // pins and config
  input wire logic       ring_pos_pin,
  input wire logic       ring_neg_pin,
  input wire logic       off_hook_pin,
  input wire logic       off_hook_pin_en,
  input wire logic       cid_mode,
  // line-side controls
  input wire logic       isolation_loopback,
  input wire logic       ext_line_loop,
  input wire logic       hybrid_connect,
  input wire logic       receive_path_on,
  input wire logic       onhook_monitor,
  input wire logic       line_off_hook
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_ok;
  logic srst;
  assign wr_ok = reg_wr && clk_en;
  assign srst  = wr_ok && reg_addr == plc_pkg::ADDR_CTRL_A && reg_wdata[7];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // register port
  chk_read_answer: assert property (reg_rd && clk_en |=> reg_rvalid)
    else $error("read strobe not answered");
  chk_rdata_hold: assert property (!(reg_rd && clk_en) && !srst
    |=> $stable(reg_rdata)) else $error("read data moved");
  chk_soft_clear: assert property (srst |=> !(isolation_loopback
    || serial_width_16 || ext_line_loop || hybrid_connect
    || receive_path_on || line_off_hook || onhook_monitor))
    else $error("soft reset left state set");
  chk_loop_bit: assert property (wr_ok && reg_addr == 5'h01 && !srst
    |=> isolation_loopback == $past(reg_wdata[1]))
    else $error("loopback bit wrong");
  chk_ctrl_b_bits: assert property (wr_ok && reg_addr == 5'h02
    |=> {ext_line_loop, hybrid_connect, receive_path_on}
    == {$past(reg_wdata[3]), $past(reg_wdata[1]), $past(reg_wdata[0])})
    else $error("control b bits wrong");
  chk_reserved_zero: assert property (reg_rd && clk_en
    && (reg_addr == 5'h03 || reg_addr == 5'h04) |=> reg_rdata == 8'h00)
    else $error("reserved register not zero");

  // ==========================================================
  // framing and hook
  chk_grant_given: assert property (sec_frame_req && !serial_width_16
    && clk_en |=> sec_frame_grant) else $error("request not granted");
  chk_grant_width: assert property ($past(serial_width_16)
    |-> !sec_frame_grant) else $error("grant in 16-bit mode");
  chk_width_sticky: assert property (serial_width_16 && !srst
    |=> serial_width_16) else $error("width select cleared");
  chk_monitor_hook: assert property (onhook_monitor
    |-> !line_off_hook) else $error("monitor while off-hook");
  chk_hook_drop: assert property (wr_ok && reg_addr == 5'h05
    && !reg_wdata[0] && !off_hook_pin_en ##1 !off_hook_pin_en
    |=> !line_off_hook) else $error("off-hook did not drop");
endmodule : plc_regs_props

bind plc_regs plc_regs_props #(
  .RING_HOLD_CYC(RING_HOLD_CYC),
  .OFFHOOK_HOLD_CYC(OFFHOOK_HOLD_CYC)
) plc_regs_props_i (.*);

// file: test/test_phone_line_ctrl_regs_one_to_five.sv
module test_phone_line_ctrl_regs_one_to_five;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} plc_row_s;
  logic       sys_clk, rst, reg_wr, reg_rd, sec_frame_req, off_hook_pin;
  logic       off_hook_pin_en, cid_mode, reg_rvalid, sec_frame_grant;
  logic       serial_width_16, ring_pos_pin, ring_neg_pin;
  logic       isolation_loopback, ext_line_loop, hybrid_connect;
  logic       receive_path_on, onhook_monitor, line_off_hook;
  logic       clk_en;
  logic [1:0] ring_sel;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int         mismatches, n_compared;
  // receive path on before isolation loopback
  plc_row_s   rows [8] = '{'{5'h02, 8'h0F, 8'h0B}, '{5'h02, 8'h00, 8'h00},
    '{5'h03, 8'hFF, 8'h00}, '{5'h04, 8'hFF, 8'h00}, '{5'h02, 8'h01, 8'h01},
    '{5'h01, 8'h7E, 8'h02}, '{5'h01, 8'h00, 8'h00}, '{5'h05, 8'hF6, 8'h00}};

  plc_regs #(.RING_HOLD_CYC(20), .OFFHOOK_HOLD_CYC(8)) plc_regs_i
    (.*);
  plc_line_model plc_line_model_i (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    int n;
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge sys_clk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (reg_rvalid !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
    check("reg_rdata", reg_rdata, e);
  endtask : rd

  task automatic hook(input logic e);
    @(negedge sys_clk);
    check("line_off_hook", {7'h0, line_off_hook}, {7'h0, e});
  endtask : hook

  // hang guard
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {clk_en, rst, reg_wr, reg_rd, sec_frame_req, off_hook_pin} = 6'h30;
    {off_hook_pin_en, cid_mode, ring_sel, reg_addr, reg_wdata} = '0;
    {mismatches, n_compared} = '0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    for (int a = 1; a < 6; a++)
      rd(a[4:0], 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // 16-bit mode, then soft reset undoes it
    sec_frame_req = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("grant", {7'h0, sec_frame_grant}, 8'h01);
    wr(5'h02, 8'h01);
    wr(5'h01, 8'h01);
    wr(5'h01, 8'h00);
    rd(5'h01, 8'h01);
    check("grant", {7'h0, sec_frame_grant}, 8'h00);
    wr(5'h01, 8'h80);
    rd(5'h01, 8'h00);
    rd(5'h02, 8'h00);
    sec_frame_req = 1'b0;
    // a write while the enable is low must leave no trace
    clk_en = 1'b0;
    wr(5'h02, 8'h0B);
    clk_en = 1'b1;
    rd(5'h02, 8'h00);
    // ring flags and timed clear
    ring_sel = 2'b01;
    repeat (4) @(negedge sys_clk);
    rd(5'h05, 8'h24);
    ring_sel = 2'b10;
    repeat (4) @(negedge sys_clk);
    rd(5'h05, 8'h44);
    ring_sel = 2'b00;
    // let the negative ring level leave the synchroniser
    repeat (3) @(negedge sys_clk);
    rd(5'h05, 8'h04);
    repeat (20) @(negedge sys_clk);
    rd(5'h05, 8'h00);
    // monitor, then off-hook clears the ring flag
    wr(5'h05, 8'h08);
    hook(1'b0);
    check("monitor", {7'h0, onhook_monitor}, 8'h01);
    ring_sel = 2'b01;
    repeat (4) @(negedge sys_clk);
    ring_sel = 2'b00;
    wr(5'h05, 8'h00);
    wr(5'h05, 8'h01);
    hook(1'b1);
    rd(5'h05, 8'h01);
    // holdoff only outside caller-id mode
    wr(5'h05, 8'h00);
    wr(5'h05, 8'h01);
    hook(1'b0);
    repeat (10) @(negedge sys_clk);
    hook(1'b1);
    cid_mode = 1'b1;
    wr(5'h05, 8'h00);
    wr(5'h05, 8'h01);
    hook(1'b1);
    // enabled pin is ORed in
    wr(5'h05, 8'h00);
    {off_hook_pin_en, off_hook_pin} = 2'b11;
    repeat (4) @(negedge sys_clk);
    hook(1'b1);
    off_hook_pin_en = 1'b0;
    repeat (2) @(negedge sys_clk);
    hook(1'b0);
    conclude();
  end
endmodule : test_phone_line_ctrl_regs_one_to_five

// file: verilog/plc_pkg.sv
package plc_pkg;

  // ==========================================================
  // register addresses
  localparam logic [4:0] ADDR_CTRL_A    = 5'h01;
  localparam logic [4:0] ADDR_CTRL_B    = 5'h02;
  localparam logic [4:0] ADDR_RSVD_3    = 5'h03;
  localparam logic [4:0] ADDR_RSVD_4    = 5'h04;
  localparam logic [4:0] ADDR_HOOK_RING = 5'h05;

  // ==========================================================
  // line_interface_control_a fields
  localparam int BIT_SOFT_RESET   = 7;
  localparam int BIT_ISO_LOOPBACK = 1;
  localparam int BIT_WIDTH_SELECT = 0;

  // ==========================================================
  // line_interface_control_b fields
  localparam int BIT_EXT_LINE_LOOP   = 3;
  localparam int BIT_HYBRID_CONNECT  = 1;
  localparam int BIT_RECEIVE_PATH_ON = 0;

  // ==========================================================
  // hook_and_ring_control fields
  localparam int BIT_RING_NEG      = 6;
  localparam int BIT_RING_POS      = 5;
  localparam int BIT_ONHOOK_MON    = 3;
  localparam int BIT_RING_FLAG     = 2;
  localparam int BIT_OFF_HOOK      = 0;

  // ==========================================================
  // reset values
  localparam logic       RST_BIT     = 1'b0;
  localparam logic [7:0] RST_RDATA   = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int RING_HOLD_MS      = 4500;
  localparam int RING_HOLD_CYC     = RING_HOLD_MS * (1000000 / CLK_PERIOD_NS);
  localparam int OFFHOOK_HOLD_CYC  = 1000;

endpackage : plc_pkg

// file: verilog/plc_regs.sv
// Behaviour
// - soft reset bit clears all, self-clears
// - isolation loopback bit drives barrier loopback
// - width select: 15-bit with requests, 16-bit none
// - width select sticks until reset
// - ext line loop bit enables analog loopback
// - hybrid connect bit joins hybrid transmit path
// - receive path on bit enables receive path
// - ring_neg_flag mirrors negative ring presence
// - ring_pos_flag mirrors positive ring presence
// - onhook monitor enables low-power line monitoring
// - ring flag set on ring, timed clear
// - off_hook bit ORed with enabled pin
// - caller-id mode skips off-hook counter
// - registers reached only via serial port
module plc_regs #(
  parameter int unsigned RING_HOLD_CYC    = plc_pkg::RING_HOLD_CYC,
  parameter int unsigned OFFHOOK_HOLD_CYC = plc_pkg::OFFHOOK_HOLD_CYC
) (
  // clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // register port from the buffered serial port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // serial framing
  input  wire logic       sec_frame_req,
  output logic            sec_frame_grant,
  output logic            serial_width_16,
  // line-side pins, asynchronous
  input  wire logic       ring_pos_pin,
  input  wire logic       ring_neg_pin,
  input  wire logic       off_hook_pin,
  // configuration from neighbouring registers
  input  wire logic       off_hook_pin_en,
  input  wire logic       cid_mode,
  // line-side controls
  output logic            isolation_loopback,
  output logic            ext_line_loop,
  output logic            hybrid_connect,
  output logic            receive_path_on,
  output logic            onhook_monitor,
  output logic            line_off_hook
);

  // ==========================================================
  // declarations
  logic       iso_loop_q;
  logic       width_sel_q;
  logic       ext_loop_q;
  logic       hybrid_q;
  logic       rx_on_q;
  logic       onhook_mon_q;
  logic       off_hook_q;
  logic       ring_flag;
  logic [1:0] ring_pos_sync_q;
  logic [1:0] ring_neg_sync_q;
  logic [1:0] hook_pin_sync_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       grant_q;
  logic       line_hook_q;
  logic       monitor_q;
  logic [31:0] hold_cnt_q;
  logic       wr_a;
  logic       wr_b;
  logic       wr_hr;
  logic       soft_rst;
  logic       ring_pos_s;
  logic       ring_neg_s;
  logic       hook_pin_s;
  logic       off_req;
  logic       hold_busy;
  logic       going_on_hook;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ring_pos_sync_q <= 2'h0;
      ring_neg_sync_q <= 2'h0;
      hook_pin_sync_q <= 2'h0;
    end
    else if (clk_en)
    begin
      ring_pos_sync_q <= {ring_pos_sync_q[0], ring_pos_pin};
      ring_neg_sync_q <= {ring_neg_sync_q[0], ring_neg_pin};
      hook_pin_sync_q <= {hook_pin_sync_q[0], off_hook_pin};
    end
  end

  assign ring_pos_s = ring_pos_sync_q[1];
  assign ring_neg_s = ring_neg_sync_q[1];
  assign hook_pin_s = hook_pin_sync_q[1];

  // ==========================================================
  // write decode
  // only the serial port path reaches these strobes
  assign wr_a  = reg_wr && (reg_addr == plc_pkg::ADDR_CTRL_A);
  assign wr_b  = reg_wr && (reg_addr == plc_pkg::ADDR_CTRL_B);
  assign wr_hr = reg_wr && (reg_addr == plc_pkg::ADDR_HOOK_RING);
  // soft reset acts on the write edge and is never stored,
  // so it reads back as zero
  assign soft_rst = wr_a && reg_wdata[plc_pkg::BIT_SOFT_RESET];

  // ==========================================================
  // line_interface_control_a
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      iso_loop_q <= plc_pkg::RST_BIT;
    else if (clk_en)
    begin
      if (soft_rst)
        iso_loop_q <= plc_pkg::RST_BIT;
      else if (wr_a)
        iso_loop_q <= reg_wdata[plc_pkg::BIT_ISO_LOOPBACK];
    end
  end

  // sticky: a zero write cannot clear it, only a reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      width_sel_q <= plc_pkg::RST_BIT;
    else if (clk_en)
    begin
      if (soft_rst)
        width_sel_q <= plc_pkg::RST_BIT;
      else if (wr_a && reg_wdata[plc_pkg::BIT_WIDTH_SELECT])
        width_sel_q <= 1'b1;
    end
  end

  // ==========================================================
  // line_interface_control_b
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_loop_q <= plc_pkg::RST_BIT;
      hybrid_q   <= plc_pkg::RST_BIT;
      rx_on_q    <= plc_pkg::RST_BIT;
    end
    else if (clk_en)
    begin
      if (soft_rst)
      begin
        ext_loop_q <= plc_pkg::RST_BIT;
        hybrid_q   <= plc_pkg::RST_BIT;
        rx_on_q    <= plc_pkg::RST_BIT;
      end
      else if (wr_b)
      begin
        ext_loop_q <= reg_wdata[plc_pkg::BIT_EXT_LINE_LOOP];
        hybrid_q   <= reg_wdata[plc_pkg::BIT_HYBRID_CONNECT];
        rx_on_q    <= reg_wdata[plc_pkg::BIT_RECEIVE_PATH_ON];
      end
    end
  end

  // ==========================================================
  // hook_and_ring_control writable bits
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      onhook_mon_q <= plc_pkg::RST_BIT;
      off_hook_q   <= plc_pkg::RST_BIT;
    end
    else if (clk_en)
    begin
      if (soft_rst)
      begin
        onhook_mon_q <= plc_pkg::RST_BIT;
        off_hook_q   <= plc_pkg::RST_BIT;
      end
      else if (wr_hr)
      begin
        onhook_mon_q <= reg_wdata[plc_pkg::BIT_ONHOOK_MON];
        off_hook_q   <= reg_wdata[plc_pkg::BIT_OFF_HOOK];
      end
    end
  end

  // ==========================================================
  // ring detection
  plc_ring_timer #(
    .HOLD_CYC    (RING_HOLD_CYC)
  ) u_ring_timer (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .clk_en      (clk_en),
    .clr         (soft_rst || line_hook_q),
    .ring_pos    (ring_pos_s),
    .ring_neg    (ring_neg_s),
    .ring_flag_q (ring_flag)
  );

  // ==========================================================
  // off-hook control and hold-off counter
  // register bit and enabled pin are simply ORed
  assign off_req   = off_hook_q || (off_hook_pin_en && hook_pin_s);
  assign hold_busy = (hold_cnt_q != 32'h00000000);
  // caller-id mode drops the line without arming the counter
  assign going_on_hook = line_hook_q && !off_req;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hold_cnt_q <= 32'h00000000;
    else if (clk_en)
    begin
      if (soft_rst)
        hold_cnt_q <= 32'h00000000;
      else if (going_on_hook && !cid_mode)
        hold_cnt_q <= OFFHOOK_HOLD_CYC[31:0];
      else if (hold_busy)
        hold_cnt_q <= hold_cnt_q - 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      line_hook_q <= plc_pkg::RST_BIT;
    else if (clk_en)
    begin
      if (soft_rst)
        line_hook_q <= plc_pkg::RST_BIT;
      else
        line_hook_q <= off_req && !hold_busy;
    end
  end

  // monitoring only while the line stays on-hook
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      monitor_q <= plc_pkg::RST_BIT;
    else if (clk_en)
    begin
      if (soft_rst)
        monitor_q <= plc_pkg::RST_BIT;
      else
        monitor_q <= onhook_mon_q && !off_req;
    end
  end

  // ==========================================================
  // secondary frame grant
  // 16-bit mode has no request bit in the data field
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      grant_q <= plc_pkg::RST_BIT;
    else if (clk_en)
      grant_q <= sec_frame_req && !width_sel_q;
  end

  // ==========================================================
  // read path
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q  <= plc_pkg::RST_RDATA;
      rvalid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rvalid_q <= reg_rd;
      if (reg_rd)
      begin
        rdata_q <= plc_pkg::RST_RDATA;
        case (reg_addr)
          plc_pkg::ADDR_CTRL_A:
          begin
            rdata_q[plc_pkg::BIT_ISO_LOOPBACK] <= iso_loop_q;
            rdata_q[plc_pkg::BIT_WIDTH_SELECT] <= width_sel_q;
          end
          plc_pkg::ADDR_CTRL_B:
          begin
            rdata_q[plc_pkg::BIT_EXT_LINE_LOOP]   <= ext_loop_q;
            rdata_q[plc_pkg::BIT_HYBRID_CONNECT]  <= hybrid_q;
            rdata_q[plc_pkg::BIT_RECEIVE_PATH_ON] <= rx_on_q;
          end
          plc_pkg::ADDR_HOOK_RING:
          begin
            rdata_q[plc_pkg::BIT_RING_NEG]   <= ring_neg_s;
            rdata_q[plc_pkg::BIT_RING_POS]   <= ring_pos_s;
            rdata_q[plc_pkg::BIT_ONHOOK_MON] <= onhook_mon_q;
            rdata_q[plc_pkg::BIT_RING_FLAG]  <= ring_flag;
            rdata_q[plc_pkg::BIT_OFF_HOOK]   <= off_hook_q;
          end
          // reserved slots three and four read as zero
          default:
          begin
            rdata_q <= plc_pkg::RST_RDATA;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata          = rdata_q;
  assign reg_rvalid         = rvalid_q;
  assign sec_frame_grant    = grant_q;
  assign serial_width_16    = width_sel_q;
  assign isolation_loopback = iso_loop_q;
  assign ext_line_loop      = ext_loop_q;
  assign hybrid_connect     = hybrid_q;
  assign receive_path_on    = rx_on_q;
  assign onhook_monitor     = monitor_q;
  assign line_off_hook      = line_hook_q;

endmodule : plc_regs

// file: verilog/plc_ring_timer.sv
module plc_ring_timer #(
  parameter int unsigned HOLD_CYC = plc_pkg::RING_HOLD_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // events
  input  wire logic clr,
  input  wire logic ring_pos,
  input  wire logic ring_neg,
  // flag
  output logic      ring_flag_q
);

  logic [31:0] hold_cnt_q;
  logic        expire;

  // ==========================================================
  // hold counter since last positive ring
  assign expire = (hold_cnt_q == HOLD_CYC[31:0] - 32'h00000001);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hold_cnt_q <= 32'h00000000;
    else if (clk_en)
    begin
      if (clr || ring_pos || !ring_flag_q)
        hold_cnt_q <= 32'h00000000;
      else if (!expire)
        hold_cnt_q <= hold_cnt_q + 32'h00000001;
    end
  end

  // ==========================================================
  // flag: going off-hook clears even with ring present
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ring_flag_q <= plc_pkg::RST_BIT;
    else if (clk_en)
    begin
      if (clr)
        ring_flag_q <= 1'b0;
      else if (ring_pos || ring_neg)
        ring_flag_q <= 1'b1;
      else if (ring_flag_q && expire)
        ring_flag_q <= 1'b0;
    end
  end

endmodule : plc_ring_timer
